/* hdl/ebcl_loader.sv */
/*
 * boot configuration loader: strap, self-test wait, then command and data
 * fetch from a serial memory and dispatch strobes toward the filter core.
 * assumes the filter core takes each strobe in one cycle and that a pulled
 * up bus holds the released serial pins.
 */
`timescale 1ns/1ps
module ebcl_loader import ebcl_pkg::*; #(
    parameter int SELFTEST_WAIT = SELFTEST_CYCLES,
    parameter int LINK_HZ = LINK_CLK_HZ
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic linkClk,
    input wire logic bootSelect,
    output logic memorySelectN,
    output logic memorySelectOe,
    output logic bootSerialClock,
    output logic bootSerialClockOe,
    output logic mosi,
    output logic mosiOe,
    input wire logic miso,
    output logic cfgRegWrStb,
    output logic cfgFirCoefStb,
    output logic cfgFirStage,
    output logic cfgIirCoefStb,
    output logic cfgCoefSetChoiceStb,
    output logic cfgPatWrStb,
    output logic cfgPatBuiltinStb,
    output logic cfgFilterStartStb,
    output logic [23:0] cfgAddr,
    output logic [23:0] cfgData,
    output logic eepromBoot,
    output logic loaderBusy,
    output logic loaderDone
);

    localparam logic [31:0] SELFTEST_LAST = 32'(SELFTEST_WAIT - 1);
    localparam logic [31:0] STRAP_LAST = 32'(STRAP_SETTLE - 1);
    localparam logic [10:0] FIR_LIMIT = 11'(FIR_MAX_COEF);
    localparam logic [10:0] IIR_LAST = 11'(IIR_COEF_COUNT - 1);
    localparam logic [10:0] PAT_LIMIT = 11'(PAT_MAX_WORDS);

    ebcl_state_t state_q, state_d;
    logic [31:0] timer_q, timer_d;
    logic bootEeprom_q, bootEeprom_d;
    logic [15:0] addr_q, addr_d;
    logic [7:0] cmd_q, cmd_d;
    logic [1:0] step_q, step_d;
    logic [23:0] cnt1_q, cnt1_d, cnt2_q, cnt2_d;
    logic [10:0] idx_q, idx_d;
    logic reqTgl_q, reqTgl_d, rdWord_q, rdWord_d;
    logic regWr_q, regWr_d, firStb_q, firStb_d, firStage_q, firStage_d;
    logic iirStb_q, iirStb_d, coefStb_q, coefStb_d;
    logic patStb_q, patStb_d, patRom_q, patRom_d, start_q, start_d;
    logic [23:0] outAddr_q, outAddr_d, outData_q, outData_d;
    logic busy_q, busy_d, done_q, done_d;
    logic bootS1_q, bootS2_q;
    logic ackS1_q, ackS2_q, ackSeen_q;
    logic ackEvent, linkAck;
    logic [23:0] rdData;
    logic firLast;

    // serial engine on the link clock
    ebcl_spi_reader #(
        .LINK_HZ(LINK_HZ)
    ) u_reader (
        .linkClk(linkClk),
        .rst_n(rst_n),
        .reqToggle(reqTgl_q),
        .rdAddr(addr_q),
        .rdWord(rdWord_q),
        .ackToggle(linkAck),
        .rdData(rdData),
        .memorySelectN(memorySelectN),
        .memorySelectOe(memorySelectOe),
        .bootSerialClock(bootSerialClock),
        .bootSerialClockOe(bootSerialClockOe),
        .mosi(mosi),
        .mosiOe(mosiOe),
        .miso(miso)
    );

    // strap pin and link acknowledge both arrive asynchronously
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bootS1_q <= 1'b0;
            bootS2_q <= 1'b0;
            ackS1_q <= 1'b0;
            ackS2_q <= 1'b0;
            ackSeen_q <= 1'b0;
        end else begin
            bootS1_q <= bootSelect;
            bootS2_q <= bootS1_q;
            ackS1_q <= linkAck;
            ackS2_q <= ackS1_q;
            ackSeen_q <= ackS2_q;
        end
    end

    // read data is held by the link until the next request, so safe here
    assign ackEvent = ackS2_q ^ ackSeen_q;
    assign firLast = (cnt1_q == 24'h000001 && cnt2_q == 24'h000000) ||
                     (cnt1_q == 24'h000000 && cnt2_q == 24'h000001);

    // sequencer next state
    always_comb begin
        state_d = state_q;
        timer_d = timer_q;
        bootEeprom_d = bootEeprom_q;
        addr_d = addr_q;
        cmd_d = cmd_q;
        step_d = step_q;
        cnt1_d = cnt1_q;
        cnt2_d = cnt2_q;
        idx_d = idx_q;
        reqTgl_d = reqTgl_q;
        rdWord_d = rdWord_q;
        regWr_d = 1'b0;
        firStb_d = 1'b0;
        firStage_d = firStage_q;
        iirStb_d = 1'b0;
        coefStb_d = 1'b0;
        patStb_d = 1'b0;
        patRom_d = 1'b0;
        start_d = 1'b0;
        outAddr_d = outAddr_q;
        outData_d = outData_q;
        busy_d = busy_q;
        done_d = done_q;
        case (state_q)
            ST_STRAP: begin
                timer_d = 32'(timer_q + 32'h1);
                if (timer_q == STRAP_LAST) begin
                    bootEeprom_d = bootS2_q;
                    timer_d = 32'h0;
                    state_d = ST_SELFTEST;
                end
            end
            ST_SELFTEST: begin
                timer_d = 32'(timer_q + 32'h1);
                if (timer_q == SELFTEST_LAST) begin
                    if (bootEeprom_q) begin
                        addr_d = CFG_START_ADDR;
                        busy_d = 1'b1;
                        state_d = ST_CMD_REQ;
                    end else begin
                        state_d = ST_HOST_BOOT;
                    end
                end
            end
            ST_CMD_REQ: begin
                rdWord_d = 1'b0;
                reqTgl_d = ~reqTgl_q;
                state_d = ST_CMD_WAIT;
            end
            ST_CMD_WAIT: if (ackEvent) begin
                cmd_d = rdData[7:0];
                addr_d = 16'(addr_q + BYTES_PER_CMD);
                state_d = ST_DECODE;
            end
            ST_DECODE: begin
                step_d = 2'h0;
                idx_d = 11'h000;
                case (cmd_q)
                    CMD_REGISTER_WRITE, CMD_CUSTOM_FIR, CMD_CUSTOM_IIR,
                    CMD_COEF_SET_CHOICE, CMD_CUSTOM_PATTERN: begin
                        state_d = ST_WORD_REQ;
                    end
                    CMD_BUILTIN_PATTERN_SELECT: begin
                        patRom_d = 1'b1;
                        state_d = ST_CMD_REQ;
                    end
                    CMD_FILTER_START: begin
                        start_d = 1'b1;
                        busy_d = 1'b0;
                        done_d = 1'b1;
                        state_d = ST_DONE;
                    end
                    default: begin
                        // unknown codes skipped like a nop
                        state_d = ST_CMD_REQ;
                    end
                endcase
            end
            ST_WORD_REQ: begin
                rdWord_d = 1'b1;
                reqTgl_d = ~reqTgl_q;
                state_d = ST_WORD_WAIT;
            end
            ST_WORD_WAIT: if (ackEvent) begin
                // first byte lands in the top bits
                outData_d = rdData;
                addr_d = 16'(addr_q + BYTES_PER_WORD);
                state_d = ST_DISPATCH;
            end
            ST_DISPATCH: begin
                // back to command fetch unless more words are due
                state_d = ST_CMD_REQ;
                case (cmd_q)
                    CMD_REGISTER_WRITE: begin
                        if (step_q == 2'h0) begin
                            outAddr_d = outData_q;
                            step_d = 2'h1;
                            state_d = ST_WORD_REQ;
                        end else begin
                            regWr_d = 1'b1;
                        end
                    end
                    CMD_CUSTOM_FIR: begin
                        // two counts, then stage one then stage two
                        if (step_q == 2'h0) begin
                            cnt1_d = outData_q;
                            step_d = 2'h1;
                            state_d = ST_WORD_REQ;
                        end else if (step_q == 2'h1) begin
                            cnt2_d = outData_q;
                            step_d = 2'h2;
                            if (cnt1_q != 24'h0 || outData_q != 24'h0) begin
                                state_d = ST_WORD_REQ;
                            end
                        end else begin
                            if (cnt1_q != 24'h0) begin
                                firStage_d = 1'b0;
                                cnt1_d = 24'(cnt1_q - 24'h1);
                            end else begin
                                firStage_d = 1'b1;
                                cnt2_d = 24'(cnt2_q - 24'h1);
                            end
                            // words past 255 are read but dropped
                            if (idx_q < FIR_LIMIT) begin
                                firStb_d = 1'b1;
                                outAddr_d = {13'h0000, idx_q};
                                idx_d = 11'(idx_q + 11'h001);
                            end
                            if (cnt1_q == 24'h000001) begin
                                idx_d = 11'h000;
                            end
                            if (!firLast) begin
                                state_d = ST_WORD_REQ;
                            end
                        end
                    end
                    CMD_CUSTOM_IIR: begin
                        // eight words, index gives the fixed order
                        iirStb_d = 1'b1;
                        outAddr_d = {13'h0000, idx_q};
                        idx_d = 11'(idx_q + 11'h001);
                        if (idx_q != IIR_LAST) begin
                            state_d = ST_WORD_REQ;
                        end
                    end
                    CMD_COEF_SET_CHOICE: begin
                        coefStb_d = 1'b1;
                    end
                    default: begin
                        if (step_q == 2'h0) begin
                            cnt1_d = outData_q;
                            step_d = 2'h1;
                            if (outData_q != 24'h0) begin
                                state_d = ST_WORD_REQ;
                            end
                        end else begin
                            cnt1_d = 24'(cnt1_q - 24'h1);
                            // beyond 1024 words nothing is stored
                            if (idx_q < PAT_LIMIT) begin
                                patStb_d = 1'b1;
                                outAddr_d = {13'h0000, idx_q};
                                idx_d = 11'(idx_q + 11'h001);
                            end
                            if (cnt1_q != 24'h000001) begin
                                state_d = ST_WORD_REQ;
                            end
                        end
                    end
                endcase
            end
            default: begin
                // finished or host boot: bus stays released
                state_d = state_q;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_STRAP;
            timer_q <= 32'h0;
            bootEeprom_q <= 1'b0;
            addr_q <= CFG_START_ADDR;
            cmd_q <= CMD_NOP;
            step_q <= 2'h0;
            cnt1_q <= 24'h0;
            cnt2_q <= 24'h0;
            idx_q <= 11'h000;
            reqTgl_q <= 1'b0;
            rdWord_q <= 1'b0;
            regWr_q <= 1'b0;
            firStb_q <= 1'b0;
            firStage_q <= 1'b0;
            iirStb_q <= 1'b0;
            coefStb_q <= 1'b0;
            patStb_q <= 1'b0;
            patRom_q <= 1'b0;
            start_q <= 1'b0;
            outAddr_q <= 24'h0;
            outData_q <= 24'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            bootEeprom_q <= bootEeprom_d;
            addr_q <= addr_d;
            cmd_q <= cmd_d;
            step_q <= step_d;
            cnt1_q <= cnt1_d;
            cnt2_q <= cnt2_d;
            idx_q <= idx_d;
            reqTgl_q <= reqTgl_d;
            rdWord_q <= rdWord_d;
            regWr_q <= regWr_d;
            firStb_q <= firStb_d;
            firStage_q <= firStage_d;
            iirStb_q <= iirStb_d;
            coefStb_q <= coefStb_d;
            patStb_q <= patStb_d;
            patRom_q <= patRom_d;
            start_q <= start_d;
            outAddr_q <= outAddr_d;
            outData_q <= outData_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    // filter-side outputs, all straight from flops
    assign cfgRegWrStb = regWr_q;
    assign cfgFirCoefStb = firStb_q;
    assign cfgFirStage = firStage_q;
    assign cfgIirCoefStb = iirStb_q;
    assign cfgCoefSetChoiceStb = coefStb_q;
    assign cfgPatWrStb = patStb_q;
    assign cfgPatBuiltinStb = patRom_q;
    assign cfgFilterStartStb = start_q;
    assign cfgAddr = outAddr_q;
    assign cfgData = outData_q;
    assign eepromBoot = bootEeprom_q;
    assign loaderBusy = busy_q;
    assign loaderDone = done_q;

endmodule // ebcl_loader

/* hdl/ebcl_pkg.sv */
/*
 * constants, command codes and state types of the boot configuration loader
 * assumes a 40 MHz system clock and a separate link clock for the spi engine
 */
package ebcl_pkg;

    // clocks and timing
    localparam int CLK_HZ = 40_000_000;
    localparam int SELFTEST_MS = 60;
    localparam int SELFTEST_CYCLES = (CLK_HZ / 1000) * SELFTEST_MS;
    localparam int STRAP_SETTLE = 3;
    localparam int SCK_HZ = 1_024_000;
    localparam int LINK_CLK_HZ = 83_333_333;

    // memory layout
    localparam logic [15:0] CFG_START_ADDR = 16'h0010;
    localparam logic [15:0] BYTES_PER_CMD = 16'h0001;
    localparam logic [15:0] BYTES_PER_WORD = 16'h0003;

    // serial transaction shape
    localparam logic [7:0] EE_READ_OPCODE = 8'h03;
    localparam logic [5:0] LAST_BIT_CMD = 6'h1f;
    localparam logic [5:0] LAST_BIT_WORD = 6'h2f;
    localparam logic [5:0] FIRST_RX_BIT = 6'h18;

    // command codes
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_REGISTER_WRITE = 8'h01;
    localparam logic [7:0] CMD_CUSTOM_FIR = 8'h02;
    localparam logic [7:0] CMD_CUSTOM_IIR = 8'h03;
    localparam logic [7:0] CMD_COEF_SET_CHOICE = 8'h04;
    localparam logic [7:0] CMD_CUSTOM_PATTERN = 8'h05;
    localparam logic [7:0] CMD_BUILTIN_PATTERN_SELECT = 8'h06;
    localparam logic [7:0] CMD_FILTER_START = 8'h07;

    // capacity limits
    localparam int FIR_MAX_COEF = 255;
    localparam int IIR_COEF_COUNT = 8;
    localparam int PAT_MAX_WORDS = 1024;

    // main sequencer, gray along the usual path
    typedef enum logic [3:0] {
        ST_STRAP = 4'h0,
        ST_SELFTEST = 4'h1,
        ST_CMD_REQ = 4'h3,
        ST_CMD_WAIT = 4'h2,
        ST_DECODE = 4'h6,
        ST_WORD_REQ = 4'h7,
        ST_WORD_WAIT = 4'h5,
        ST_DISPATCH = 4'h4,
        ST_DONE = 4'hc,
        ST_HOST_BOOT = 4'hd
    } ebcl_state_t;

    // link engine
    typedef enum logic [1:0] {
        LS_IDLE = 2'h0,
        LS_LOW = 2'h1,
        LS_HIGH = 2'h3,
        LS_END = 2'h2
    } ebcl_link_state_t;

endpackage

/* hdl/ebcl_spi_reader.sv */
/*
 * spi mode 0 read engine on the link clock: opcode, 16-bit address, then
 * one or three data bytes; assumes a toggle request with address and length
 * held stable by the requester until the acknowledge toggle returns
 */
`timescale 1ns/1ps
module ebcl_spi_reader import ebcl_pkg::*; #(
    parameter int LINK_HZ = LINK_CLK_HZ
) (
    input wire logic linkClk,
    input wire logic rst_n,
    input wire logic reqToggle,
    input wire logic [15:0] rdAddr,
    input wire logic rdWord,
    output logic ackToggle,
    output logic [23:0] rdData,
    output logic memorySelectN,
    output logic memorySelectOe,
    output logic bootSerialClock,
    output logic bootSerialClockOe,
    output logic mosi,
    output logic mosiOe,
    input wire logic miso
);

    // half period of the serial clock, rounded down, never below one
    localparam int HALF_RAW = LINK_HZ / (2 * SCK_HZ);
    localparam int HALF = (HALF_RAW < 1) ? 1 : HALF_RAW;
    localparam logic [15:0] HALF_LAST = 16'(HALF - 1);

    ebcl_link_state_t state_q, state_d;
    logic reqS1_q, reqS2_q, reqSeen_q;
    logic misoS1_q, misoS2_q;
    logic [15:0] div_q, div_d;
    logic [5:0] bit_q, bit_d;
    logic [23:0] tx_q, tx_d;
    logic [23:0] rx_q, rx_d;
    logic ack_q, ack_d;
    logic csn_q, csn_d, oe_q, oe_d, sck_q, sck_d, mosi_q, mosi_d;
    logic halfDone;
    logic [5:0] lastBit;

    // request toggle and data pin both cross in from outside this domain
    always_ff @(posedge linkClk or negedge rst_n) begin
        if (!rst_n) begin
            reqS1_q <= 1'b0;
            reqS2_q <= 1'b0;
            reqSeen_q <= 1'b0;
            misoS1_q <= 1'b0;
            misoS2_q <= 1'b0;
        end else begin
            reqS1_q <= reqToggle;
            reqS2_q <= reqS1_q;
            reqSeen_q <= reqS2_q;
            misoS1_q <= miso;
            misoS2_q <= misoS1_q;
        end
    end

    assign halfDone = (div_q == HALF_LAST);
    assign lastBit = rdWord ? LAST_BIT_WORD : LAST_BIT_CMD;

    // serial sequencer next state
    always_comb begin
        state_d = state_q;
        div_d = halfDone ? 16'h0000 : 16'(div_q + 16'h0001);
        bit_d = bit_q;
        tx_d = tx_q;
        rx_d = rx_q;
        ack_d = ack_q;
        csn_d = csn_q;
        oe_d = oe_q;
        sck_d = sck_q;
        mosi_d = mosi_q;
        case (state_q)
            LS_IDLE: begin
                div_d = 16'h0000;
                if (reqS2_q != reqSeen_q) begin
                    csn_d = 1'b0;
                    oe_d = 1'b1;
                    sck_d = 1'b0;
                    tx_d = {EE_READ_OPCODE, rdAddr};
                    mosi_d = EE_READ_OPCODE[7];
                    bit_d = 6'h00;
                    state_d = LS_LOW;
                end
            end
            LS_LOW: if (halfDone) begin
                // mode 0: sample on the rising edge
                sck_d = 1'b1;
                if (bit_q >= FIRST_RX_BIT) begin
                    rx_d = {rx_q[22:0], misoS2_q};
                end
                state_d = LS_HIGH;
            end
            LS_HIGH: if (halfDone) begin
                sck_d = 1'b0;
                if (bit_q == lastBit) begin
                    csn_d = 1'b1;
                    state_d = LS_END;
                end else begin
                    bit_d = 6'(bit_q + 6'h01);
                    tx_d = {tx_q[22:0], 1'b0};
                    mosi_d = tx_q[22];
                    state_d = LS_LOW;
                end
            end
            default: if (halfDone) begin
                // let go of the bus between transactions
                oe_d = 1'b0;
                ack_d = ~ack_q;
                state_d = LS_IDLE;
            end
        endcase
    end

    // serial sequencer registers
    always_ff @(posedge linkClk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= LS_IDLE;
            div_q <= 16'h0000;
            bit_q <= 6'h00;
            tx_q <= 24'h000000;
            rx_q <= 24'h000000;
            ack_q <= 1'b0;
            csn_q <= 1'b1;
            oe_q <= 1'b0;
            sck_q <= 1'b0;
            mosi_q <= 1'b0;
        end else begin
            state_q <= state_d;
            div_q <= div_d;
            bit_q <= bit_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            ack_q <= ack_d;
            csn_q <= csn_d;
            oe_q <= oe_d;
            sck_q <= sck_d;
            mosi_q <= mosi_d;
        end
    end

    assign ackToggle = ack_q;
    assign rdData = rx_q;
    assign memorySelectN = csn_q;
    assign memorySelectOe = oe_q;
    assign bootSerialClock = sck_q;
    assign bootSerialClockOe = oe_q;
    assign mosi = mosi_q;
    assign mosiOe = oe_q;

endmodule // ebcl_spi_reader

/* test/ebcl_loader_assertions.sv */
/* port checker for the boot loader, bound onto the loader.
   assumes the loader's own parameter for the self-test wait */
`timescale 1ns/1ps
module ebcl_loader_assertions #(parameter int SELFTEST_WAIT = 20) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic linkClk,
    input wire logic memorySelectN,
    input wire logic memorySelectOe,
    input wire logic bootSerialClock,
    input wire logic bootSerialClockOe,
    input wire logic mosiOe,
    input wire logic eepromBoot,
    input wire logic loaderDone,
    input wire logic cfgFilterStartStb,
    input wire logic cfgIirCoefStb,
    input wire logic [23:0] cfgAddr
);
    int upCnt;
    // cycles since release, saturating so it never wraps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) upCnt <= 0;
        else if (upCnt < SELFTEST_WAIT) upCnt <= upCnt + 1;
    end
    AST_SELFTEST_QUIET: assert property (
        @(posedge clk) disable iff (!rst_n)
        upCnt < SELFTEST_WAIT |-> !memorySelectOe) else $error("early bus");
    AST_HOST_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
        !eepromBoot |-> !memorySelectOe) else $error("bus in host boot");
    AST_SEL_DRIVEN: assert property (
        @(posedge linkClk) disable iff (!rst_n)
        !memorySelectN |-> memorySelectOe) else $error("select not driven");
    AST_OE_TOGETHER: assert property (
        @(posedge linkClk) disable iff (!rst_n)
        {bootSerialClockOe, mosiOe} == {2{memorySelectOe}}) else $error("oe");
    AST_SCK_IDLE: assert property (
        @(posedge linkClk) disable iff (!rst_n)
        memorySelectN |-> !bootSerialClock) else $error("sck not idle low");
    AST_DONE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        loaderDone |=> loaderDone) else $error("done dropped");
    AST_START_ONCE: assert property (@(posedge clk) disable iff (!rst_n)
        cfgFilterStartStb |=> !cfgFilterStartStb [*8]) else $error("start");
    AST_IIR_INDEX: assert property (@(posedge clk) disable iff (!rst_n)
        cfgIirCoefStb |-> cfgAddr < 24'h8) else $error("iir index");
    // main scenarios reached
    CV_START: cover property (@(posedge clk) cfgFilterStartStb);
    CV_IIR_LAST: cover property (@(posedge clk)
        cfgIirCoefStb && cfgAddr[2:0] == 3'h7);
    CV_SEL: cover property (@(posedge linkClk) !memorySelectN);
endmodule // ebcl_loader_assertions
bind ebcl_loader ebcl_loader_assertions #(.SELFTEST_WAIT(SELFTEST_WAIT)) chk (.*);

/* test/ebcl_mem_model.sv */
/* serial memory at the far side: mode 0, 16-bit address, 8 kbyte.
   assumes pins released by the loader are pulled high */
`timescale 1ns/1ps
module ebcl_mem_model (
    input wire logic sck,
    input wire logic csN,
    input wire logic mosi,
    output logic miso
);
    logic [7:0] mem [0:8191];
    logic [23:0] hdr;
    logic [7:0] sh;
    logic [15:0] ptr, firstAddr;
    int nBit, badOp = 0, nTrans = 0;
    initial miso = 1'b1;
    // each select fall starts a new frame
    always @(negedge csN) begin
        nBit = 0;
        nTrans++;
    end
    always @(posedge sck) if (!csN) begin
        if (nBit < 24) hdr = {hdr[22:0], mosi};
        nBit++;
        if (nBit == 24) begin
            badOp += int'(hdr[23:16] != 8'h03);
            ptr = hdr[15:0];
            if (nTrans == 1) firstAddr = ptr;
        end
        // a byte counts once its last bit is taken, not on a frame edge
        if (nBit > 24 && nBit % 8 == 0) ptr++;
    end
    // data shifts out on falling clock
    always @(negedge sck) if (!csN && nBit >= 24) begin
        if (nBit % 8 == 0) sh = mem[ptr];
        miso <= sh[7 - nBit % 8];
    end
    // released line returns to the pull-up
    always @(posedge csN) miso <= 1'b1;
endmodule // ebcl_mem_model

/* test/tb_top.sv */
/* top bench: loader, memory model and a strobe scoreboard.
   assumes loader, package, model and checker compiled before it */
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, linkClk = 0, rst_n = 0, bootSelect = 1;
    logic memorySelectN, memorySelectOe, bootSerialClock, bootSerialClockOe;
    logic mosi, mosiOe, cfgFirStage, eepromBoot, loaderBusy, loaderDone;
    logic [6:0] stb;
    logic [23:0] cfgAddr, cfgData;
    logic [57:0] expQ [$];
    logic [57:0] e;
    int err_count = 0, cmp_count = 0, cyc = 0;
    wire miso;
    // released pins float high on the pull-ups
    wire csW = memorySelectOe ? memorySelectN : 1'b1;
    wire sckW = bootSerialClockOe ? bootSerialClock : 1'b1;
    wire mosiW = mosiOe ? mosi : 1'b1;
    ebcl_loader #(.SELFTEST_WAIT(20)) dut (.clk, .rst_n, .linkClk, .bootSelect,
        .memorySelectN, .memorySelectOe, .bootSerialClock, .bootSerialClockOe,
        .mosi, .mosiOe, .miso, .cfgRegWrStb(stb[0]), .cfgFirCoefStb(stb[1]),
        .cfgFirStage, .cfgIirCoefStb(stb[2]), .cfgCoefSetChoiceStb(stb[3]),
        .cfgPatWrStb(stb[4]), .cfgPatBuiltinStb(stb[5]),
        .cfgFilterStartStb(stb[6]), .cfgAddr, .cfgData, .eepromBoot,
        .loaderBusy, .loaderDone);
    ebcl_mem_model mdl (.sck(sckW), .csN(csW), .mosi(mosiW), .miso);
    // link clock offset so the domains never line up
    always #12.5 clk = ~clk;
    initial #3.7 forever #6 linkClk = ~linkClk;
    task automatic finish_test();
        if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(string n, logic [23:0] x, logic [23:0] s);
        cmp_count++;
        if (x !== s) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic ex(logic [1:0] m, logic [7:0] v, logic [23:0] a, d);
        expQ.push_back({m, v, a, d});
    endtask
    task automatic w3(int a, logic [23:0] d);
        {mdl.mem[a], mdl.mem[a+1], mdl.mem[a+2]} = d;
    endtask
    task automatic do_reset(logic b);
        rst_n <= 1'b0;
        bootSelect <= b;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    // each strobe against the next expected entry; empty queue never matches
    always @(posedge clk) if (rst_n && |stb) begin
        e = expQ.size() ? expQ.pop_front() : '1;
        chk("strobes", 24'(e[55:48]), 24'({stb, cfgFirStage & stb[1]}));
        chk("busy", 24'(!stb[6]), 24'(loaderBusy));
        if (e[56]) chk("cfgAddr", e[47:24], cfgAddr);
        if (e[57]) chk("cfgData", e[23:0], cfgData);
    end
    // hang guard, well above the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            err_count++;
            finish_test();
        end
    end
    // header bytes hold start codes, the tail holds pattern selects
    task automatic eeprom_boot();
        for (int i = 0; i < 8192; i++) mdl.mem[i] = i < 16 ? 8'h07 : 8'h06;
        mdl.mem[16'h10] = 8'h00;
        mdl.mem[16'h11] = 8'h01;
        w3(16'h12, 24'h20);
        w3(16'h15, 24'h240);
        mdl.mem[16'h18] = 8'h02;
        w3(16'h19, 24'h1);
        w3(16'h1c, 24'h1);
        w3(16'h1f, 24'h22e);
        w3(16'h22, 24'hffffb9);
        mdl.mem[16'h25] = 8'h03;
        ex(2'h3, 8'h02, 24'h20, 24'h240);
        ex(2'h3, 8'h04, 24'h0, 24'h22e);
        ex(2'h3, 8'h05, 24'h0, 24'hffffb9);
        for (int i = 0; i < 8; i++) begin
            w3(16'h26 + 3 * i, 24'(i * 24'h111111));
            ex(2'h3, 8'h08, 24'(i), 24'(i * 24'h111111));
        end
        mdl.mem[16'h3e] = 8'h04;
        w3(16'h3f, 24'h2200);
        mdl.mem[16'h42] = 8'h05;
        w3(16'h43, 24'h2);
        w3(16'h46, 24'h178f);
        w3(16'h49, 24'hfb5);
        mdl.mem[16'h4c] = 8'h09;
        mdl.mem[16'h4e] = 8'h07;
        ex(2'h2, 8'h10, 24'h0, 24'h2200);
        ex(2'h3, 8'h20, 24'h0, 24'h178f);
        ex(2'h3, 8'h20, 24'h1, 24'hfb5);
        ex(2'h0, 8'h40, 24'h0, 24'h0);
        ex(2'h0, 8'h80, 24'h0, 24'h0);
        do_reset(1'b1);
        for (int i = 0; i < 60000 && loaderDone !== 1'b1; i++) @(posedge clk);
        repeat (4000) @(posedge clk);
        chk("pending", 24'(expQ.size()), 24'h0);
        chk("firstAddr", 24'h10, 24'(mdl.firstAddr));
        chk("endAddr", 24'h4f, 24'(mdl.ptr));
        chk("badOpcode", 24'h0, 24'(mdl.badOp));
        chk("done", 24'h3, 24'({eepromBoot, loaderDone}));
    endtask
    task automatic host_boot();
        int n;
        n = mdl.nTrans;
        do_reset(1'b0);
        repeat (3000) @(posedge clk);
        chk("hostFrames", 24'(n), 24'(mdl.nTrans));
        chk("hostFlags", 24'h0,
            24'({loaderBusy, loaderDone, eepromBoot}));
    endtask
    initial begin
        eeprom_boot();
        host_boot();
        finish_test();
    end
endmodule // tb_top
